// File: logic/serial_status_cfg.svh
// offsets, field positions and counts for the serial status block
`ifndef SERIAL_STATUS_CFG_SVH
`define SERIAL_STATUS_CFG_SVH

// readable locations filled by a status request
`define OFF_ERROR_FLAGS 10'h2ea
`define OFF_SENSE_OR_IN_LOW 10'h2eb
`define OFF_IN_COUNT_HIGH 10'h2ec
`define OFF_OUT_COUNT 10'h2ed

// error flag bit positions
`define BIT_FRAMING 7
`define BIT_OVERRUN 6
`define BIT_PARITY 5
`define BIT_OVERFLOW 4
`define BIT_ILLEGAL 3
`define BIT_NOT_READY 2
`define BIT_BLOCK 1
`define BIT_COMMAND 0

// configuration encodings
`define WORD_SIZE_8 2'h0
`define BAUD_CODE_300 4'h8
`define PORT_IDX_1 2'h0
`define PORT_IDX_4 2'h3

// buffer sizes and reset values
`define IN_BUF_DEPTH 8
`define OUT_BUF_DEPTH 32
`define FLAGS_RESET 8'h00

`endif

// File: logic/serial_status_pkg.sv
// types shared by the serial status block
package serial_status_pkg;

  typedef enum logic [2:0] {
    cmd_start_concurrent,
    cmd_block_output,
    cmd_configure,
    cmd_control,
    cmd_close,
    cmd_unknown
  } cmd_type;

  // monitor bits: [2] data set ready, [1] clear to send, [0] carrier
  typedef struct packed {
    logic [1:0] word_size;
    logic [3:0] baud_code;
    logic [2:0] monitor;
    logic [1:0] port;
    logic both_dirs;
    logic parity_check;
  } port_config_type;

  typedef struct packed {
    logic dsr;
    logic cts;
    logic carrier_detect_line;
  } ready_lines_type;

  typedef struct packed {
    logic [7:0] data;
    logic stop_ok;
    logic parity_ok;
    logic missed;
  } rx_char_type;

  typedef struct packed {
    cmd_type code;
    logic with_input;
    logic block_bad;
  } command_type;

endpackage

// File: logic/serial_status.sv
// serial port status and error reporting with its input buffer
// Notes on behaviour
// - framing flag when stop bit missing
// - module checks framing only for short words
// - framing flag raised on arrival, not readout
// - framing cleared by idle status, configure, control
// - other flags cleared by any command
// - overrun flag on first stored char after loss
// - parity flag only when checking; status clears
// - full buffer overwrites oldest; overflow flag
// - illegal option for short-word concurrent input
// - illegal option also sets command error
// - not-ready flag when monitored line off
// - data block error on bad output block
// - command error and nak on bad command
// - active status returns input and output counts
// - output count never exceeds thirty-two
// - idle status returns sense byte
// - line history spans since last idle status
// - ports 2-4 report missing lines as on
// - data set ready field in top bits
// - ready field zero when always off
// - clear-to-send field 48/32/16/0
// - carrier field 12/8/4/0
// - lowest sense bit is receive line level
`timescale 1ns/1ps
`include "serial_status_cfg.svh"

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `IN_BUF_DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  // fill level
  output logic [CNT_W-1:0] o_count
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] count;
  } fifo_state_type;

  fifo_state_type state;
  fifo_state_type next_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] advance(input logic [PTR_W-1:0] p);
    advance = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign o_out_valid = (state.count != '0);
  // a full buffer still takes a word when one leaves in the same cycle
  assign o_in_ready = (state.count != CNT_W'(DEPTH)) || i_out_ready;
  assign o_out_data = mem[state.rd];
  assign o_count = state.count;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wr = advance(state.wr);
    end
    if (pop) begin
      next_state.rd = advance(state.rd);
    end
    if (push && !pop) begin
      next_state.count = state.count + CNT_W'(1);
    end else if (pop && !push) begin
      next_state.count = state.count - CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // storage needs no reset; only the pointers qualify it
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[state.wr] <= i_in_data;
    end
  end
endmodule // byte_fifo

module serial_status
  import serial_status_pkg::*;
#(
  parameter int IN_DEPTH = `IN_BUF_DEPTH,
  parameter int OUT_DEPTH = `OUT_BUF_DEPTH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // port configuration
  input wire port_config_type i_config,
  // readiness and receive lines, high is on or mark
  input wire ready_lines_type i_lines,
  input wire logic i_receive_data_line,
  // commands from the host
  input wire logic i_cmd_valid,
  input wire command_type i_cmd,
  output logic o_cmd_ack,
  output logic o_cmd_nak,
  output logic o_concurrent_active,
  // status request and location reads
  input wire logic i_status_req,
  input wire logic i_rd_en,
  input wire logic [9:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // received characters into the input buffer
  input wire logic i_rx_valid,
  input wire rx_char_type i_rx_char,
  output logic o_rx_ready,
  // input buffer drain
  output logic o_data_valid,
  output logic [7:0] o_data,
  input wire logic i_data_ready,
  // output buffer occupancy
  input wire logic i_out_push,
  input wire logic i_out_pop,
  output logic o_out_full
);
  localparam int CNT_W = $clog2(IN_DEPTH + 1);

  typedef struct packed {
    logic [7:0] flags;
    logic active;
    ready_lines_type ever_on;
    ready_lines_type ever_off;
    logic [3:0][7:0] snap;
    logic [5:0] out_count;
    logic [7:0] rd_data;
    logic ack;
    logic nak;
  } status_state_type;

  status_state_type state;
  status_state_type next_state;
  logic [CNT_W-1:0] in_count;
  logic fifo_in_ready;
  logic fifo_full;
  logic discard_oldest;
  logic rx_taken;

  // lines a port does not wire are reported as always on
  function automatic ready_lines_type port_lines(
    input ready_lines_type raw, input logic [1:0] port);
    port_lines = raw;
    if (port != `PORT_IDX_1) begin
      port_lines.cts = 1'b1;
      port_lines.carrier_detect_line = 1'b1;
    end
    if (port == `PORT_IDX_4) begin
      port_lines.dsr = 1'b1;
    end
  endfunction

  // two-bit history field: on now, then always-on / not-always-off
  function automatic logic [1:0] sense_field(
    input logic now, input logic was_on, input logic was_off);
    sense_field = now ? {1'b1, !was_off} : {1'b0, was_on};
  endfunction

  assign fifo_full = (in_count == CNT_W'(IN_DEPTH));
  // newest character wins: the oldest is dropped to make room
  assign discard_oldest = fifo_full && i_rx_valid;
  assign rx_taken = i_rx_valid && fifo_in_ready;
  assign o_rx_ready = fifo_in_ready;

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(IN_DEPTH),
    .CNT_W(CNT_W)
  ) input_buffer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(i_rx_valid),
    .i_in_data(i_rx_char.data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_data_valid),
    .o_out_data(o_data),
    .i_out_ready(i_data_ready || discard_oldest),
    .o_count(in_count)
  );

  always_comb begin
    ready_lines_type lines;
    ready_lines_type hist_on;
    ready_lines_type hist_off;
    logic [7:0] clr;
    logic [7:0] set;
    logic short_word;
    logic starts;
    logic [15:0] in_count_16;
    lines = port_lines(i_lines, i_config.port);
    // history as it stands including the present sample
    hist_on = state.ever_on | lines;
    hist_off = state.ever_off | ~lines;
    clr = 8'h00;
    set = 8'h00;
    short_word = (i_config.word_size != `WORD_SIZE_8);
    starts = i_cmd_valid && (i_cmd.code == cmd_start_concurrent ||
      i_cmd.code == cmd_block_output);
    in_count_16 = 16'(in_count);
    next_state = state;
    next_state.ack = 1'b0;
    next_state.nak = 1'b0;

    if (i_status_req && !state.active) begin
      next_state.ever_on = lines;
      next_state.ever_off = ~lines;
    end else begin
      next_state.ever_on = hist_on;
      next_state.ever_off = hist_off;
    end

    // received character events, flagged as the character lands
    if (rx_taken) begin
      if (short_word && !i_rx_char.stop_ok) begin
        set[`BIT_FRAMING] = 1'b1;
      end
      if (i_rx_char.missed) begin
        set[`BIT_OVERRUN] = 1'b1;
      end
      if (i_config.parity_check && !i_rx_char.parity_ok) begin
        set[`BIT_PARITY] = 1'b1;
      end
      if (fifo_full) begin
        set[`BIT_OVERFLOW] = 1'b1;
      end
    end

    // commands: flags from the previous operation go, framing stays unless configure or control
    if (i_cmd_valid) begin
      clr = 8'h7f;
      if (i_cmd.code == cmd_configure || i_cmd.code == cmd_control) begin
        clr[`BIT_FRAMING] = 1'b1;
      end
      unique case (i_cmd.code)
        cmd_start_concurrent: begin
          if (short_word && i_cmd.with_input &&
              (i_config.both_dirs ||
               i_config.baud_code > `BAUD_CODE_300)) begin
            set[`BIT_ILLEGAL] = 1'b1;
            set[`BIT_COMMAND] = 1'b1;
          end
        end
        cmd_block_output: begin
          if (i_cmd.block_bad) begin
            set[`BIT_BLOCK] = 1'b1;
          end
        end
        cmd_unknown: begin
          set[`BIT_COMMAND] = 1'b1;
        end
        cmd_configure, cmd_control: begin
          // a busy port cannot be reconfigured
          if (state.active) begin
            set[`BIT_COMMAND] = 1'b1;
          end
        end
        cmd_close: begin
        end
        default: set[`BIT_COMMAND] = 1'b1;
      endcase
      // unmonitored lines never block an operation
      if (starts && ((i_config.monitor & ~lines) != 3'h0)) begin
        set[`BIT_NOT_READY] = 1'b1;
      end
      if (set[`BIT_COMMAND] || set[`BIT_NOT_READY] || set[`BIT_BLOCK]) begin
        next_state.nak = 1'b1;
      end else begin
        next_state.ack = 1'b1;
        if (i_cmd.code == cmd_start_concurrent) begin
          next_state.active = 1'b1;
        end else if (i_cmd.code == cmd_close) begin
          next_state.active = 1'b0;
        end
      end
    end

    // status request: capture the locations, then clear
    if (i_status_req) begin
      next_state.snap[0] = state.flags | set;
      if (state.active) begin
        next_state.snap[1] = in_count_16[7:0];
        next_state.snap[2] = in_count_16[15:8];
        next_state.snap[3] = {2'h0, state.out_count};
        clr[`BIT_PARITY] = 1'b1;
        clr[`BIT_OVERFLOW] = 1'b1;
      end else begin
        next_state.snap[1] = {
          sense_field(lines.dsr, hist_on.dsr,
            hist_off.dsr),
          sense_field(lines.cts, hist_on.cts,
            hist_off.cts),
          sense_field(lines.carrier_detect_line,
            hist_on.carrier_detect_line,
            hist_off.carrier_detect_line),
          1'b0,
          i_receive_data_line};
        next_state.snap[2] = 8'h00;
        next_state.snap[3] = 8'h00;
        clr[`BIT_FRAMING] = 1'b1;
        clr[`BIT_PARITY] = 1'b1;
        clr[`BIT_OVERFLOW] = 1'b1;
        clr[`BIT_ILLEGAL] = 1'b1;
        clr[`BIT_NOT_READY] = 1'b1;
      end
    end
    // an event in the clearing cycle survives the clear
    next_state.flags = (state.flags & ~clr) | set;

    // output buffer occupancy, capped at its depth
    if (i_out_push && !i_out_pop &&
        state.out_count < 6'(OUT_DEPTH)) begin
      next_state.out_count = state.out_count + 6'h01;
    end else if (i_out_pop && !i_out_push && state.out_count != 6'h00) begin
      next_state.out_count = state.out_count - 6'h01;
    end

    // location reads, unmapped addresses read zero
    if (i_rd_en) begin
      unique case (i_rd_addr)
        `OFF_ERROR_FLAGS: next_state.rd_data = state.snap[0];
        `OFF_SENSE_OR_IN_LOW: next_state.rd_data = state.snap[1];
        `OFF_IN_COUNT_HIGH: next_state.rd_data = state.snap[2];
        `OFF_OUT_COUNT: next_state.rd_data = state.snap[3];
        default: next_state.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state <= '0;
      state.flags <= `FLAGS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign o_cmd_ack = state.ack;
  assign o_cmd_nak = state.nak;
  assign o_concurrent_active = state.active;
  assign o_rd_data = state.rd_data;
  assign o_out_full = (state.out_count == 6'(OUT_DEPTH));
endmodule // serial_status

// File: bench/serial_status_properties.sv
// port assertions for the serial status block
`timescale 1ns/1ps
module serial_status_properties
  import serial_status_pkg::*;
#(
  parameter int IN_DEPTH = 8,
  parameter int OUT_DEPTH = 32
) (
  // clock and reset
  input logic i_clk_sys,
  input logic i_reset,
  // watched ports
  input port_config_type i_config,
  input ready_lines_type i_lines,
  input logic i_cmd_valid,
  input command_type i_cmd,
  input logic o_cmd_ack,
  input logic o_cmd_nak,
  input logic o_concurrent_active,
  input logic i_rd_en,
  input logic [9:0] i_rd_addr,
  input logic [7:0] o_rd_data,
  input logic i_rx_valid,
  input logic o_rx_ready,
  input logic o_data_valid
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic start, blk, short_bad, dark;
  assign start = i_cmd_valid && i_cmd.code == cmd_start_concurrent;
  assign blk = i_cmd_valid && i_cmd.code == cmd_block_output;
  assign short_bad = i_cmd.with_input && i_config.word_size != 2'h0
    && (i_config.both_dirs || i_config.baud_code > 4'h8);
  // port 1 only: the other ports fake missing lines as on
  assign dark = i_config.port == 2'h0 && |(i_config.monitor & ~i_lines);

  a_one_answer: assert property (i_cmd_valid |=> o_cmd_ack != o_cmd_nak)
    else $error("command not answered exactly once");
  a_no_stray: assert property ((o_cmd_ack || o_cmd_nak) |-> $past(i_cmd_valid))
    else $error("answer without command");
  a_illegal_nak: assert property (start && short_bad |=> o_cmd_nak)
    else $error("short word start not refused");
  a_unknown_nak: assert property (i_cmd_valid && i_cmd.code == cmd_unknown |=> o_cmd_nak)
    else $error("unknown command not refused");
  a_busy_config: assert property (i_cmd_valid && i_cmd.code == cmd_configure
    && o_concurrent_active |=> o_cmd_nak)
    else $error("configure while active not refused");
  a_not_ready: assert property ((start || blk) && dark |=> o_cmd_nak)
    else $error("monitored line off not refused");
  a_block_bad: assert property (blk && i_cmd.block_bad |=> o_cmd_nak)
    else $error("bad block not refused");
  a_rx_taken: assert property (i_rx_valid |-> o_rx_ready)
    else $error("received character refused");
  a_rx_stored: assert property (i_rx_valid |=> o_data_valid)
    else $error("received character not stored");
  a_start_active: assert property (o_cmd_ack && $past(start) |-> o_concurrent_active)
    else $error("accepted start not active");
  a_unmapped_zero: assert property (i_rd_en && (i_rd_addr < 10'h2ea
    || i_rd_addr > 10'h2ed) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");

  c_refused: cover property (o_cmd_nak);
  c_active_rx: cover property (o_concurrent_active && i_rx_valid);
  c_idle_read: cover property (i_rd_en && !o_concurrent_active);
endmodule // serial_status_properties

// File: bench/host_model.sv
// host side: commands, status requests and location reads
`timescale 1ns/1ps
module host_model
  import serial_status_pkg::*;
(
  // clock
  input wire logic i_clk_sys,
  // commands
  output logic o_cmd_valid,
  output command_type o_cmd,
  input wire logic i_nak,
  // status and reads
  output logic o_status_req,
  output logic o_rd_en,
  output logic [9:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  initial begin
    o_cmd_valid = 1'h0;
    o_cmd = command_type'(5'h00);
    o_status_req = 1'h0;
    o_rd_en = 1'h0;
    o_rd_addr = 10'h000;
  end
  // one-cycle command; answer read after the next edge
  task automatic send(input command_type c, output logic n);
    @(negedge i_clk_sys);
    o_cmd_valid = 1'h1;
    o_cmd = c;
    @(negedge i_clk_sys);
    o_cmd_valid = 1'h0;
    o_cmd = command_type'(~c);
    n = i_nak;
  endtask
  task automatic status();
    @(negedge i_clk_sys);
    o_status_req = 1'h1;
    @(negedge i_clk_sys);
    o_status_req = 1'h0;
  endtask
  // released address is scrambled so stale values are never reused
  task automatic read(input logic [9:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    o_rd_en = 1'h1;
    o_rd_addr = a;
    @(negedge i_clk_sys);
    o_rd_en = 1'h0;
    o_rd_addr = ~a;
    d = i_rd_data;
  endtask
endmodule // host_model

// File: bench/serial_status_bench.sv
// self-checking bench for the serial status block
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("Error %s expected %h seen %h", what, exp, got); \
  end \
end
module serial_status_bench
  import serial_status_pkg::*;
;
  logic i_clk_sys, i_reset, i_receive_data_line, i_rx_valid;
  logic i_data_ready, i_out_push, i_out_pop, i_cmd_valid;
  logic i_status_req, i_rd_en, o_cmd_ack, o_cmd_nak, o_concurrent_active;
  logic o_rx_ready, o_data_valid, o_out_full;
  logic [9:0] i_rd_addr;
  logic [7:0] o_rd_data, o_data;
  port_config_type i_config;
  ready_lines_type i_lines;
  rx_char_type i_rx_char;
  command_type i_cmd;
  int bad_count, comparisons;

  serial_status uut (.i_clk_sys, .i_reset, .i_config, .i_lines,
    .i_receive_data_line, .i_cmd_valid, .i_cmd, .o_cmd_ack, .o_cmd_nak,
    .o_concurrent_active, .i_status_req, .i_rd_en, .i_rd_addr, .o_rd_data,
    .i_rx_valid, .i_rx_char, .o_rx_ready, .o_data_valid, .o_data,
    .i_data_ready, .i_out_push, .i_out_pop, .o_out_full);
  host_model host (.i_clk_sys, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd),
    .i_nak(o_cmd_nak), .o_status_req(i_status_req), .o_rd_en(i_rd_en),
    .o_rd_addr(i_rd_addr), .i_rd_data(o_rd_data));

  initial begin
    i_clk_sys = 1'h0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic set_cfg(input logic [1:0] w, input logic [3:0] b,
      input logic [2:0] m, input logic d);
    @(negedge i_clk_sys);
    i_config = '{w, b, m, 2'h0, d, 1'h1};
  endtask
  task automatic look(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.read(a, d);
    `CHECK("location", e, d)
  endtask
  task automatic issue(input cmd_type c, input logic w, input logic b,
      input logic e);
    logic n;
    host.send('{c, w, b}, n);
    `CHECK("refusal", e, n)
  endtask
  task automatic refused(input cmd_type c, input logic w, input logic b,
      input logic [7:0] e);
    issue(c, w, b, 1'h1);
    host.status();
    look(10'h2ea, e);
  endtask

  task automatic t_reset_sense();
    look(10'h2ea, 8'h00);
    look(10'h3ff, 8'h00);
    host.status();
    look(10'h2eb, 8'hfd);
    look(10'h2ec, 8'h00);
    @(negedge i_clk_sys);
    i_lines = 3'h5;
    i_receive_data_line = 1'h0;
    @(negedge i_clk_sys);
    i_lines = 3'h7;
    host.status();
    look(10'h2eb, 8'hec);
    @(negedge i_clk_sys);
    i_lines = 3'h0;
    host.status();
    look(10'h2eb, 8'h54);
    host.status();
    look(10'h2eb, 8'h00);
    @(negedge i_clk_sys);
    i_config.port = 2'h3;
    host.status();
    host.status();
    look(10'h2eb, 8'hfc);
    @(negedge i_clk_sys);
    i_config.port = 2'h0;
    i_lines = 3'h7;
  endtask

  task automatic t_refusals();
    set_cfg(2'h1, 4'h8, 3'h0, 1'h1);
    refused(cmd_start_concurrent, 1'h1, 1'h0, 8'h09);
    set_cfg(2'h2, 4'h9, 3'h0, 1'h0);
    refused(cmd_start_concurrent, 1'h1, 1'h0, 8'h09);
    set_cfg(2'h0, 4'h8, 3'h2, 1'h0);
    i_lines = 3'h5;
    refused(cmd_start_concurrent, 1'h0, 1'h0, 8'h04);
    refused(cmd_block_output, 1'h0, 1'h0, 8'h04);
    set_cfg(2'h0, 4'h8, 3'h5, 1'h0);
    issue(cmd_block_output, 1'h0, 1'h0, 1'h0);
    i_lines = 3'h7;
    refused(cmd_block_output, 1'h0, 1'h1, 8'h02);
    refused(cmd_unknown, 1'h0, 1'h0, 8'h01);
  endtask

  // eight-bit input: module ignores the stop bit, host checks it
  task automatic t_active();
    set_cfg(2'h0, 4'h8, 3'h0, 1'h0);
    issue(cmd_start_concurrent, 1'h1, 1'h0, 1'h0);
    issue(cmd_configure, 1'h0, 1'h0, 1'h1);
    for (int i = 1; i <= 9; i++) begin
      @(negedge i_clk_sys);
      i_rx_valid = 1'h1;
      i_rx_char = '{8'(i), i < 9, i < 9, i == 9};
    end
    @(negedge i_clk_sys);
    i_rx_valid = 1'h0;
    i_rx_char = ~i_rx_char;
    i_out_push = 1'h1;
    repeat (33) @(negedge i_clk_sys);
    i_out_push = 1'h0;
    `CHECK("out_full", 1'h1, o_out_full)
    host.status();
    look(10'h2eb, 8'h08);
    look(10'h2ec, 8'h00);
    look(10'h2ed, 8'h20);
    look(10'h2ea, 8'h71);
    @(negedge i_clk_sys);
    i_out_pop = 1'h1;
    @(negedge i_clk_sys);
    i_out_pop = 1'h0;
    host.status();
    look(10'h2ed, 8'h1f);
    look(10'h2ea, 8'h41);
    i_data_ready = 1'h1;
    for (int i = 2; i <= 9; i++) begin
      `CHECK("drained", 8'(i), o_data)
      @(negedge i_clk_sys);
    end
    i_data_ready = 1'h0;
    `CHECK("data_valid", 1'h0, o_data_valid)
    issue(cmd_close, 1'h0, 1'h0, 1'h0);
    `CHECK("active", 1'h0, o_concurrent_active)
  endtask

  task automatic t_framing();
    set_cfg(2'h1, 4'h8, 3'h0, 1'h0);
    issue(cmd_start_concurrent, 1'h1, 1'h0, 1'h0);
    // a bad stop bit on a short word sets framing; close keeps it, idle status clears it
    i_config.parity_check = 1'h0;
    @(negedge i_clk_sys);
    i_rx_valid = 1'h1;
    i_rx_char = '{8'h55, 1'h0, 1'h0, 1'h0};
    @(negedge i_clk_sys);
    i_rx_valid = 1'h0;
    i_rx_char = ~i_rx_char;
    issue(cmd_close, 1'h0, 1'h0, 1'h0);
    host.status();
    look(10'h2ea, 8'h80);
    host.status();
    look(10'h2ea, 8'h00);
    // a control command alone must drop the framing flag
    @(negedge i_clk_sys);
    i_rx_valid = 1'h1;
    i_rx_char = '{8'haa, 1'h0, 1'h1, 1'h0};
    @(negedge i_clk_sys);
    i_rx_valid = 1'h0;
    i_rx_char = ~i_rx_char;
    issue(cmd_control, 1'h0, 1'h0, 1'h0);
    host.status();
    look(10'h2ea, 8'h00);
  endtask

  initial begin
    bad_count = 0;
    comparisons = 0;
    i_reset = 1'h1;
    i_config = '{2'h0, 4'h8, 3'h0, 2'h0, 1'h0, 1'h1};
    i_lines = 3'h7;
    i_receive_data_line = 1'h1;
    i_rx_valid = 1'h0;
    i_rx_char = '0;
    i_data_ready = 1'h0;
    i_out_push = 1'h0;
    i_out_pop = 1'h0;
    repeat (2) @(negedge i_clk_sys);
    i_reset = 1'h0;
    t_reset_sense();
    t_refusals();
    t_active();
    t_framing();
    report_and_stop();
  end

  // whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    bad_count++;
    report_and_stop();
  end
endmodule // serial_status_bench

bind serial_status serial_status_properties #(.IN_DEPTH(IN_DEPTH),
  .OUT_DEPTH(OUT_DEPTH)) chk (.i_clk_sys, .i_reset, .i_config, .i_lines,
  .i_cmd_valid, .i_cmd, .o_cmd_ack, .o_cmd_nak, .o_concurrent_active,
  .i_rd_en, .i_rd_addr, .o_rd_data, .i_rx_valid, .o_rx_ready,
  .o_data_valid);
